/* rtl/sfps_regs.vh */
// constants of the flash program/erase/suspend sequencer
// Behaviour
// - page program needs write enable latch; code, 24-bit address, data bytes
// - program address keeps upper bits, low byte wraps within 256-byte page
// - partial page program leaves the other bytes of the page unchanged
// - chip select must rise on a byte boundary, else command discarded
// - valid program starts timed cycle with busy held high until done
// - status read still answers while a cycle runs
// - write enable latch clears when program or erase cycle finishes
// - program and sector/block erase refused on protected address
// - quad page program needs quad enable and write enable latch
// - sector erase sets a 4K sector to ff over sector erase time
// - block erase clears 64K block or 32K half block over block time
// - chip erase takes either code, no address, over chip erase time
// - chip erase refused when any region is protected
// - suspend accepted only with suspend flag 0 and busy 1
// - suspend ignored during chip erase
// - suspend sets flag at once, busy clears within suspend latency
// - power-up leaves suspend flag cleared
// - resume needs flag 1 and busy 0; clears flag, busy within 200ns
// - quad enable lives in status bit nine
`ifndef SFPS_REGS_VH
`define SFPS_REGS_VH
`define SFPS_CMD_PP     8'h02
`define SFPS_CMD_QPP    8'h33
`define SFPS_CMD_SE     8'h20
`define SFPS_CMD_HBE    8'h52
`define SFPS_CMD_BE     8'hd8
`define SFPS_CMD_CE1    8'hc7
`define SFPS_CMD_CE2    8'h60
`define SFPS_CMD_SUSP   8'h75
`define SFPS_CMD_RES    8'h7a
`define SFPS_CMD_RDSR   8'h05
`define SFPS_CMD_RDSR2  8'h35
`define SFPS_CMD_WREN   8'h06
`define SFPS_CMD_WRDI   8'h04
`define SFPS_QE_BIT     9
`define SFPS_OP_PROG    3'h1
`define SFPS_OP_SECT    3'h2
`define SFPS_OP_HBLK    3'h3
`define SFPS_OP_BLK     3'h4
`define SFPS_OP_CHIP    3'h5
`define SFPS_PROG_NS    3000
`define SFPS_SECT_NS    30000
`define SFPS_BLK_NS     150000
`define SFPS_CHIP_NS    1000000
`define SFPS_SUS_NS     2000
`define SFPS_RESUME_NS  200
`define SFPS_CLK_NS     100
`define SFPS_FIFO_W     8
`define SFPS_FIFO_D     8
`define SFPS_FIFO_AW    3
`define SFPS_PAGE_LOW   8
`endif

/* rtl/sfps_fifo.v */
// small valid/ready fifo for program data bytes
`timescale 1ns/1ps
module sfps_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_clr,
  input  wire [W-1:0]  i_data,
  input  wire          i_valid,
  output wire          o_ready,
  output reg  [W-1:0]  o_data,
  output wire          o_valid,
  input  wire          i_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0]  wr_ptr;
  reg [AW:0]  rd_ptr;
  wire        full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire        empty = (wr_ptr == rd_ptr);
  assign o_ready = !full;
  assign o_valid = !empty;
  always @* begin
    o_data = mem[rd_ptr[AW-1:0]];
  end
  always @(posedge i_clk) begin
    if (i_valid && !full)
      mem[wr_ptr[AW-1:0]] <= i_data;
  end
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (i_clr) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (i_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (i_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // sfps_fifo

/* rtl/sfps_top.v */
// flash program/erase/suspend sequencer behind the serial pins
`timescale 1ns/1ps
`include "sfps_regs.vh"
module sfps_top #(
  parameter PROG_CYC = `SFPS_PROG_NS / `SFPS_CLK_NS,
  parameter SECT_CYC = `SFPS_SECT_NS / `SFPS_CLK_NS,
  parameter BLK_CYC  = `SFPS_BLK_NS / `SFPS_CLK_NS,
  parameter CHIP_CYC = `SFPS_CHIP_NS / `SFPS_CLK_NS,
  parameter SUS_CYC  = `SFPS_SUS_NS / `SFPS_CLK_NS
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire [3:0]  i_quad_io_lines,
  output reg  [3:0]  o_quad_io_lines,
  output reg  [3:0]  o_quad_io_oe_n,
  input  wire        i_quad_enable,
  input  wire        i_protect_complement,
  input  wire        i_sector_granularity_select,
  input  wire        i_top_bottom_select,
  input  wire [2:0]  i_block_protect_level,
  input  wire        i_addr_protected,
  input  wire        i_any_protected,
  output reg         o_busy,
  output reg         o_write_enable_latch,
  output reg         o_suspend_flag,
  output reg  [2:0]  o_op,
  output reg  [23:0] o_op_addr,
  output reg         o_op_done,
  output reg  [23:0] o_wr_addr,
  output wire [7:0]  o_wr_data,
  output wire        o_wr_valid,
  input  wire        i_wr_ready
);
  localparam RES_CYC = `SFPS_RESUME_NS / `SFPS_CLK_NS;
  localparam [7:0] RES_CYC8 = RES_CYC[7:0];
  localparam [7:0] SUS_CYC8 = SUS_CYC[7:0];
  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_SUSP = 3'b100;
  reg [1:0] rst_sync;
  wire      rst_n = rst_sync[1];
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  reg [1:0] sclk_s;
  reg [1:0] cs_s;
  reg [3:0] io_s0;
  reg [3:0] io_s1;
  reg       sclk_d;
  reg       cs_d;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 2'b00;
      cs_s   <= 2'b11;
      io_s0  <= 4'h0;
      io_s1  <= 4'h0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], i_sclk};
      cs_s   <= {cs_s[0], i_cs_n};
      io_s0  <= i_quad_io_lines;
      io_s1  <= io_s0;
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end
  end
  wire cs_low  = !cs_s[1];
  wire cs_rise = cs_s[1] && !cs_d;
  wire sclk_up = sclk_s[1] && !sclk_d && cs_low;
  // frame capture: 4 lanes after the code only for quad program
  reg [7:0]  cmd;
  reg [7:0]  shreg;
  reg [3:0]  bitcnt;
  reg [5:0]  bytecnt;
  reg [23:0] addr;
  reg [7:0]  byte_data;
  reg        byte_strobe;
  reg        quad;
  wire [7:0] sh_next = quad ? {shreg[3:0], io_s1} : {shreg[6:0], io_s1[0]};
  wire [3:0] step    = quad ? 4'h4 : 4'h1;
  wire       byte_end = (bitcnt + step) == 4'h8;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= 8'h00;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      bytecnt <= 6'h00;
      addr <= 24'h000000;
      byte_data <= 8'h00;
      byte_strobe <= 1'b0;
      quad <= 1'b0;
    end else begin
      byte_strobe <= 1'b0;
      if (!cs_low) begin
        bitcnt <= 4'h0;
        bytecnt <= 6'h00;
        quad <= 1'b0;
      end else if (sclk_up) begin
        shreg <= sh_next;
        if (byte_end) begin
          bitcnt <= 4'h0;
          if (bytecnt != 6'h3f)
            bytecnt <= bytecnt + 6'h01;
          if (bytecnt == 6'h00) begin
            cmd <= sh_next;
            quad <= (sh_next == `SFPS_CMD_QPP) && i_quad_enable;
          end else if (bytecnt < 6'h04)
            addr <= {addr[15:0], sh_next};
          else begin
            byte_data <= sh_next;
            byte_strobe <= 1'b1;
          end
        end else
          bitcnt <= bitcnt + step;
      end
    end
  end
  wire is_prog = (cmd == `SFPS_CMD_PP) || (cmd == `SFPS_CMD_QPP);
  wire is_ce   = (cmd == `SFPS_CMD_CE1) || (cmd == `SFPS_CMD_CE2);
  wire aligned = (bitcnt == 4'h0);
  reg  [2:0] state;
  reg  [31:0] tmr;
  reg  [7:0] page_lo;
  reg        busy_pend;
  reg  [7:0] res_cnt;
  wire fifo_ready;
  wire fifo_valid;
  // bytes reach the array only once the command was accepted
  wire prog_run = (state == S_RUN) && (o_op == `SFPS_OP_PROG) &&
                  !o_suspend_flag;
  wire fifo_clr = cs_low && (bytecnt == 6'h00) && (state == S_IDLE);
  wire fifo_in  = byte_strobe && is_prog && o_write_enable_latch &&
                  (state == S_IDLE);
  sfps_fifo #(
    .W  (`SFPS_FIFO_W),
    .D  (`SFPS_FIFO_D),
    .AW (`SFPS_FIFO_AW)
  ) u_fifo (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_clr   (fifo_clr),
    .i_data  (byte_data),
    .i_valid (fifo_in),
    .o_ready (fifo_ready),
    .o_data  (o_wr_data),
    .o_valid (fifo_valid),
    .i_ready (i_wr_ready && prog_run)
  );
  assign o_wr_valid = fifo_valid && prog_run;
  wire frame_ok = cs_rise && aligned;
  wire can_new  = (state == S_IDLE) && o_write_enable_latch;
  wire go_prog  = frame_ok && can_new && is_prog && bytecnt > 6'h04 &&
                  !i_addr_protected &&
                  (cmd == `SFPS_CMD_PP || i_quad_enable);
  wire go_ers   = frame_ok && can_new && bytecnt == 6'h04 &&
                  !i_addr_protected &&
                  (cmd == `SFPS_CMD_SE || cmd == `SFPS_CMD_HBE ||
                   cmd == `SFPS_CMD_BE);
  wire go_chip  = frame_ok && can_new && is_ce && bytecnt == 6'h01 &&
                  !i_any_protected;
  wire cmd1     = frame_ok && bytecnt == 6'h01;
  wire go_susp  = cmd1 && cmd == `SFPS_CMD_SUSP && state == S_RUN &&
                  !o_suspend_flag && o_op != `SFPS_OP_CHIP;
  wire go_res   = cmd1 && cmd == `SFPS_CMD_RES && o_suspend_flag &&
                  !o_busy;
  // address shown is that of the fifo head; base held from the start
  // the array only ands bytes in, so untouched bytes stay as they are
  wire       wr_take      = o_wr_valid && i_wr_ready;
  wire [7:0] next_page_lo = wr_take ? page_lo + 8'h01 : page_lo;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_lo <= 8'h00;
      o_wr_addr <= 24'h000000;
    end else if (state == S_IDLE && go_prog) begin
      page_lo <= addr[7:0];
      o_wr_addr <= addr;
    end else begin
      page_lo <= next_page_lo;
      o_wr_addr <= {o_op_addr[23:8], next_page_lo};
    end
  end
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      tmr <= 32'h00000000;
      o_busy <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_suspend_flag <= 1'b0;
      o_op <= 3'h0;
      o_op_addr <= 24'h000000;
      o_op_done <= 1'b0;
      busy_pend <= 1'b0;
      res_cnt <= 8'h00;
    end else begin
      o_op_done <= 1'b0;
      if (cmd1 && state == S_IDLE && cmd == `SFPS_CMD_WREN)
        o_write_enable_latch <= 1'b1;
      if (cmd1 && state == S_IDLE && cmd == `SFPS_CMD_WRDI)
        o_write_enable_latch <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go_prog || go_ers || go_chip) begin
            state <= S_RUN;
            o_busy <= 1'b1;
            o_op_addr <= addr;
            if (go_prog) begin
              o_op <= `SFPS_OP_PROG;
              tmr <= PROG_CYC;
            end else if (go_chip) begin
              o_op <= `SFPS_OP_CHIP;
              tmr <= CHIP_CYC;
            end else if (cmd == `SFPS_CMD_SE) begin
              o_op <= `SFPS_OP_SECT;
              tmr <= SECT_CYC;
            end else begin
              o_op <= (cmd == `SFPS_CMD_BE) ? `SFPS_OP_BLK : `SFPS_OP_HBLK;
              tmr <= BLK_CYC;
            end
          end
        end
        S_RUN: begin
          if (go_susp) begin
            o_suspend_flag <= 1'b1;
            busy_pend <= 1'b1;
            res_cnt <= SUS_CYC8;
          end else if (busy_pend) begin
            if (res_cnt <= 8'h01) begin
              busy_pend <= 1'b0;
              o_busy <= 1'b0;
              state <= S_SUSP;
            end else
              res_cnt <= res_cnt - 8'h01;
          end else if (tmr <= 32'h00000001) begin
            state <= S_IDLE;
            o_busy <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_op_done <= 1'b1;
          end else
            tmr <= tmr - 32'h00000001;
        end
        S_SUSP: begin
          if (go_res) begin
            o_suspend_flag <= 1'b0;
            res_cnt <= RES_CYC8;
            busy_pend <= 1'b1;
          end else if (busy_pend) begin
            if (res_cnt <= 8'h01) begin
              busy_pend <= 1'b0;
              o_busy <= 1'b1;
              state <= S_RUN;
            end else
              res_cnt <= res_cnt - 8'h01;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // status answer on lane 1 for either status read, also while busy
  wire [15:0] status = {6'h00, i_quad_enable, o_suspend_flag,
                        i_protect_complement, i_sector_granularity_select,
                        i_top_bottom_select, i_block_protect_level,
                        o_write_enable_latch, o_busy};
  wire sclk_dn = !sclk_s[1] && sclk_d && cs_low;
  wire rd_sr   = bytecnt != 6'h00 &&
                 (cmd == `SFPS_CMD_RDSR || cmd == `SFPS_CMD_RDSR2);
  reg  [2:0] obit;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_quad_io_lines <= 4'h0;
      o_quad_io_oe_n <= 4'hf;
      obit <= 3'h7;
    end else if (!cs_low) begin
      o_quad_io_oe_n <= 4'hf;
      obit <= 3'h7;
    end else if (rd_sr && sclk_dn) begin
      o_quad_io_oe_n <= 4'hd;
      o_quad_io_lines[1] <= (cmd == `SFPS_CMD_RDSR2) ?
                            status[{1'b1, obit}] : status[{1'b0, obit}];
      obit <= obit - 3'h1;
    end
  end
endmodule // sfps_top

/* bench/sfps_host.sv */
// serial host model that drives the flash pins
`timescale 1ns/1ps
module sfps_host (
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic [3:0] o_io,
  input  wire  [3:0] i_io,
  input  wire  [3:0] i_oe_n
);
  logic seen;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io   = 4'h0;
    seen   = 1'b0;
  end
  // msb first, nibbles when q is set
  task automatic shift(input logic [7:0] b, input int nb, input bit q);
    for (int i = 0; i < nb; i = i + (q ? 4 : 1)) begin
      if (q) o_io = b[7-i -: 4];
      else o_io[0] = b[7-i];
      #400 o_sclk = 1'b1;
      if (i_oe_n[1] === 1'b0) seen = 1'b1;
      #400 o_sclk = 1'b0;
    end
    o_io = ~o_io;
  endtask
  // cut gives the bit count of the last byte, 0 for whole
  task automatic frame(input logic [7:0] b[$], input int cut, input bit q);
    o_cs_n = 1'b0;
    #400;
    foreach (b[k]) shift(b[k], (k == b.size() - 1 && cut) ? cut : 8,
                         q && k > 0);
    #400 o_cs_n = 1'b1;
    #800;
  endtask
endmodule // sfps_host

/* bench/sfps_checker.sv */
// assertions on the flash sequencer top ports
`timescale 1ns/1ps
module sfps_checker #(parameter int SUS_CYC = 20) (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_addr_protected,
  input wire        i_any_protected,
  input wire        i_wr_ready,
  input wire        o_busy,
  input wire        o_write_enable_latch,
  input wire        o_suspend_flag,
  input wire [2:0]  o_op,
  input wire        o_op_done,
  input wire [23:0] o_wr_addr,
  input wire        o_wr_valid
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_DONE_CLEARS: assert property (o_op_done |-> ##[0:1]
    (!o_busy && !o_write_enable_latch)) else $error("done left flags set");
  AST_START_WEL: assert property ($rose(o_busy) && !o_suspend_flag
    |-> $past(o_write_enable_latch)) else $error("start without wel");
  AST_PROT: assert property ($rose(o_busy) && o_op != 3'h5
    |-> !$past(i_addr_protected)) else $error("protected op ran");
  AST_CHIP_PROT: assert property ($rose(o_busy) && o_op == 3'h5
    |-> !$past(i_any_protected)) else $error("protected chip erase");
  AST_SUS_COND: assert property ($rose(o_suspend_flag)
    |-> $past(o_busy) && $past(o_op) != 3'h5) else $error("bad suspend");
  AST_SUS_LAT: assert property ($rose(o_suspend_flag)
    |-> ##[0:SUS_CYC] !o_busy) else $error("suspend too slow");
  AST_RESUME: assert property ($fell(o_suspend_flag)
    |-> ##[0:2] o_busy) else $error("resume too slow");
  AST_OP_STEADY: assert property (o_busy && $past(o_busy)
    |-> $stable(o_op)) else $error("op changed while busy");
  AST_PAGE_WRAP: assert property (o_wr_valid && i_wr_ready ##1 o_wr_valid
    |-> o_wr_addr[23:8] == $past(o_wr_addr[23:8])) else $error("page left");
  cover property ($rose(o_suspend_flag));
  cover property (o_op_done && o_op == 3'h5);
  cover property (o_wr_valid && i_wr_ready);
endmodule // sfps_checker
bind sfps_top sfps_checker #(.SUS_CYC(SUS_CYC)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_addr_protected(i_addr_protected), .i_any_protected(i_any_protected),
  .i_wr_ready(i_wr_ready), .o_busy(o_busy),
  .o_write_enable_latch(o_write_enable_latch),
  .o_suspend_flag(o_suspend_flag), .o_op(o_op), .o_op_done(o_op_done),
  .o_wr_addr(o_wr_addr), .o_wr_valid(o_wr_valid));

/* bench/tb.sv */
// testbench for the flash program and erase sequencer
`timescale 1ns/1ps
module tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        qe        = 1'b0;
  logic        aprot     = 1'b0;
  logic        anyp      = 1'b0;
  logic        wr_rdy    = 1'b1;
  logic [5:0]  pbits     = 6'h00;
  wire         sclk, cs_n, busy, write_enable_latch, suspend_flag, done, wv;
  wire  [3:0]  hio, serial_data_in, doe_n, pin;
  wire  [2:0]  op;
  wire  [23:0] opa, wa;
  wire  [7:0]  wd;
  logic [31:0] wq[$];
  logic [7:0]  bq[$];
  logic [7:0]  ec[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  assign pin = (~doe_n & serial_data_in) | (doe_n & hio);
  always #50 i_sys_clk = ~i_sys_clk;
  sfps_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(hio), .i_io(pin),
                    .i_oe_n(doe_n));
  sfps_top #(.PROG_CYC(800), .SECT_CYC(300), .BLK_CYC(400),
             .CHIP_CYC(500), .SUS_CYC(10)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_quad_io_lines(pin), .o_quad_io_lines(serial_data_in),
    .o_quad_io_oe_n(doe_n), .i_quad_enable(qe),
    .i_protect_complement(pbits[5]), .i_sector_granularity_select(pbits[4]),
    .i_top_bottom_select(pbits[3]), .i_block_protect_level(pbits[2:0]),
    .i_addr_protected(aprot), .i_any_protected(anyp), .o_busy(busy),
    .o_write_enable_latch(write_enable_latch), .o_suspend_flag(suspend_flag), .o_op(op),
    .o_op_addr(opa), .o_op_done(done), .o_wr_addr(wa), .o_wr_data(wd),
    .o_wr_valid(wv), .i_wr_ready(wr_rdy));
  task give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // write enable, then the command; e is the expected op or 0 if refused
  task automatic go(input logic [7:0] b[$], input bit q, input int e);
    host_u.frame('{8'h06}, 0, 0);
    host_u.frame(b, 0, q);
    @(negedge i_sys_clk);
    chk("busy", e != 0, busy);
    if (e != 0) chk("op", e, op);
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && k < lim) begin
      @(negedge i_sys_clk);
      k++;
    end
    chk("done", 1, done);
    @(negedge i_sys_clk);
    chk("wel after", 0, write_enable_latch);
  endtask
  always @(posedge i_sys_clk) begin
    if (wv && wr_rdy) wq.push_back({wa, wd});
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    chk("flags", 0, {suspend_flag, write_enable_latch, busy});
    host_u.frame('{8'h75}, 0, 0);
    chk("idle suspend", 0, suspend_flag);
    host_u.frame('{8'h02, 8'h00, 8'h10, 8'h00, 8'h55}, 0, 0);
    chk("no wel", 0, busy);
    wr_rdy = 1'b0;
    bq = '{8'h02, 8'h00, 8'h12, 8'hfc};
    for (int i = 0; i < 10; i++) bq.push_back(8'(i));
    go(bq, 0, 1);
    host_u.frame('{8'h05, 8'h00}, 0, 0);
    chk("status drive", 1, host_u.seen);
    host_u.frame('{8'h20, 8'h00, 8'h00, 8'h00}, 0, 0);
    chk("op kept", 1, op);
    wr_rdy = 1'b1;
    wait_done(1000);
    chk("bytes", 8, wq.size());
    foreach (wq[i]) chk("byte", {16'h0012, 8'(252 + i), 8'(i)}, wq[i]);
    aprot = 1'b1;
    pbits = 6'h3f;
    go('{8'h20, 8'h00, 8'h00, 8'h00}, 0, 0);
    aprot = 1'b0;
    anyp = 1'b1;
    go('{8'hc7}, 0, 0);
    anyp = 1'b0;
    pbits = 6'h00;
    host_u.frame('{8'h06}, 0, 0);
    host_u.frame('{8'h20, 8'h00, 8'h00, 8'h00}, 5, 0);
    chk("cut frame", 0, busy);
    go('{8'h33, 8'h00, 8'h20, 8'h00, 8'ha5}, 1, 0);
    qe = 1'b1;
    go('{8'h33, 8'h00, 8'h20, 8'h00, 8'ha5}, 1, 1);
    wait_done(1000);
    chk("quad byte", {24'h002000, 8'ha5}, wq[$]);
    for (int i = 0; i < 5; i++) begin
      bq = '{ec[i]};
      if (i < 3) bq = {bq, 8'h03, 8'h45, 8'h67};
      go(bq, 0, i < 3 ? i + 2 : 5);
      if (i < 3) chk("op addr", 24'h034567, opa);
      host_u.frame('{8'h75}, 0, 0);
      chk("suspend", i < 3, suspend_flag);
      if (i < 3) begin
        repeat (10) @(negedge i_sys_clk);
        chk("suspended busy", 0, busy);
        host_u.frame('{8'h7a}, 0, 0);
        chk("resumed", 2'b01, {suspend_flag, busy});
      end
      wait_done(1000);
    end
    give_verdict();
  end
endmodule // tb
